// [verilog/uart_irq_ctrl.sv]
`timescale 1ns/100ps
`include "uart_irq_map.svh"

// Overview of operation
// - enable bit 3 lets modem status changes raise the modem interrupt; resets 0.
// - in auto flow mode, clear-to-send change interrupts need enable bits 3 and 7.
// - without auto flow mode, clear-to-send change interrupts need only bit 3.
// - enable bit 8 gates the auto-baud done interrupt; resets 0.
// - enable bit 9 gates the auto-baud time-out interrupt; resets 0.
// - without modem support, enable bits 3 and 7 are reserved and inert.
// - identification register gives priority and source of top pending interrupt.
// - interrupt state seen by an identification read stays stable during it.
// - events during an identification read are kept for the next read.
// - identification bit 0 is low when pending, high when idle; resets 1.
// - identification bits 3:1 hold the code of the pending interrupt.
// - codes 011 line, 010 data, 110 time-out, 001 transmit, 000 modem.
// - line status ranks highest; data available second, time-out third.
// - identification bits 8 and 9 show enabled auto-baud done and time-out.

module uart_irq_ctrl #(
  parameter bit MODEM_PRESENT = 1'b1
) (
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   RST_I,
  input  wire logic                   AWVALID_I,
  output logic                        AWREADY_O,
  input  wire logic [31:0]            AWADDR_I,
  input  wire logic [2:0]             AWPROT_I,
  input  wire logic                   WVALID_I,
  output logic                        WREADY_O,
  input  wire logic [31:0]            WDATA_I,
  input  wire logic [3:0]             WSTRB_I,
  output logic                        BVALID_O,
  input  wire logic                   BREADY_I,
  output logic      [1:0]             BRESP_O,
  input  wire logic                   ARVALID_I,
  output logic                        ARREADY_O,
  input  wire logic [31:0]            ARADDR_I,
  input  wire logic [2:0]             ARPROT_I,
  output logic                        RVALID_O,
  input  wire logic                   RREADY_I,
  output logic      [31:0]            RDATA_O,
  output logic      [1:0]             RRESP_O,
  input  wire uart_irq_pkg::irq_src_t SRC_I,
  input  wire uart_irq_pkg::uart_ctl_t CTL_I,
  output logic                        IRQ_O
);

  // ======================================================================
  // state
  logic [9:0]  en_q;
  logic [9:0]  en_d;
  logic        aw_have_q;
  logic        aw_have_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        awready_d;
  logic        wready_d;
  logic        bvalid_d;
  logic [1:0]  bresp_d;
  logic        arready_d;
  logic        rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;
  logic [2:0]  flag_q;

  // ======================================================================
  // write channel handshakes, address and data in either order
  wire         aw_fire   = AWVALID_I & AWREADY_O;
  wire         w_fire    = WVALID_I & WREADY_O;
  wire         aw_ok     = aw_fire | aw_have_q;
  wire         w_ok      = w_fire | w_have_q;
  wire         wr_go     = aw_ok & w_ok;
  wire  [31:0] wr_addr   = aw_have_q ? awaddr_q : AWADDR_I;
  wire  [31:0] wr_data   = w_have_q ? wdata_q : WDATA_I;
  wire  [3:0]  wr_strb   = w_have_q ? wstrb_q : WSTRB_I;
  wire         wr_hit_en = wr_addr[31:2] == `UIRQ_ENABLE_ADDR >> 2;
  wire         wr_hit_id = wr_addr[31:2] == `UIRQ_IDENT_ADDR >> 2;
  wire         en_wr     = wr_go & wr_hit_en & ~CTL_I.divisor_latch_select;

  // ======================================================================
  // read channel handshake and decode
  wire         ar_fire   = ARVALID_I & ARREADY_O;
  wire         rd_hit_en = ARADDR_I[31:2] == `UIRQ_ENABLE_ADDR >> 2;
  wire         rd_hit_id = ARADDR_I[31:2] == `UIRQ_IDENT_ADDR >> 2;
  wire         id_read   = ar_fire & rd_hit_id;

  // ======================================================================
  // enable register next value, reserved and absent bits stay zero
  wire  [9:0]  en_mask   = MODEM_PRESENT ? `UIRQ_EN_MASK_FULL : `UIRQ_EN_MASK_BASIC;
  wire  [9:0]  en_merge  = {wr_strb[1] ? wr_data[9:8] : en_q[9:8],
                            wr_strb[0] ? wr_data[7:0] : en_q[7:0]};
  assign en_d = en_wr ? (en_merge & en_mask) : en_q;

  wire         en_modem  = en_q[`UIRQ_EN_MODEM];
  wire         en_cts    = en_q[`UIRQ_EN_CTS];
  wire         en_done   = en_q[`UIRQ_EN_DONE];
  wire         en_tmo    = en_q[`UIRQ_EN_TMO];

  // ======================================================================
  // modem source: other line changes, and clear-to-send gated by mode
  wire         cts_ok    = ~CTL_I.auto_clear_to_send | en_cts;
  wire         modem_evt = (|SRC_I.modem_delta[3:1]) | (SRC_I.modem_delta[0] & cts_ok);
  wire         modem_set = MODEM_PRESENT & en_modem & modem_evt;

  // ======================================================================
  // sticky flags: modem, auto-baud done, auto-baud time-out
  assign flag_set = {SRC_I.autobaud_timeout_evt, SRC_I.autobaud_done_evt, modem_set};
  assign flag_clr = {CTL_I.autobaud_clear[1], CTL_I.autobaud_clear[0],
                     CTL_I.modem_status_read};

  irq_flag_bank #(
    .N      (3)
  ) u_flags (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .set_i  (flag_set),
    .clr_i  (flag_clr),
    .flag_o (flag_q)
  );

  // ======================================================================
  // reported sources after gating
  wire         modem_pend = flag_q[0] & en_modem & MODEM_PRESENT;
  wire         done_pend  = flag_q[1] & en_done;
  wire         tmo_pend   = flag_q[2] & en_tmo;
  wire         line_pend  = SRC_I.receive_line_status_cause;
  wire         data_pend  = SRC_I.receive_data_available_cause;
  wire         ctmo_pend  = SRC_I.character_timeout_cause;
  wire         tx_pend    = SRC_I.transmit_holding_empty_cause;

  // ======================================================================
  // priority encoder for the cause field
  wire  [2:0]  cause =
    line_pend ? uart_irq_pkg::CAUSE_LINE_STATUS :
    data_pend ? uart_irq_pkg::CAUSE_DATA_AVAIL  :
    ctmo_pend ? uart_irq_pkg::CAUSE_CHAR_TMO    :
    tx_pend   ? uart_irq_pkg::CAUSE_TX_EMPTY    :
                uart_irq_pkg::CAUSE_MODEM;
  wire         pending = line_pend | data_pend | ctmo_pend | tx_pend | modem_pend |
                         done_pend | tmo_pend;

  // ======================================================================
  // identification word
  wire  [31:0] ident_word = {22'h00_0000, tmo_pend, done_pend,
                             {2{CTL_I.fifo_enable}}, 2'h0,
                             cause, ~pending};
  wire  [31:0] enable_word = {22'h00_0000, en_q};
  wire  [31:0] rd_word =
    rd_hit_id ? ident_word :
    (rd_hit_en & ~CTL_I.divisor_latch_select) ? enable_word : 32'h0000_0000;

  // ======================================================================
  // write response and ready handling
  assign aw_have_d = wr_go ? 1'b0 : aw_ok;
  assign w_have_d  = wr_go ? 1'b0 : w_ok;
  assign bvalid_d  = wr_go | (BVALID_O & ~BREADY_I);
  assign bresp_d   = wr_go ? ((wr_hit_en | wr_hit_id) ? `UIRQ_RESP_OKAY : `UIRQ_RESP_SLVERR)
                           : BRESP_O;
  assign awready_d = ~aw_have_d & ~bvalid_d;
  assign wready_d  = ~w_have_d & ~bvalid_d;

  // ======================================================================
  // read data is snapshot at address acceptance and held until taken
  assign rvalid_d  = ar_fire | (RVALID_O & ~RREADY_I);
  assign arready_d = ~rvalid_d;
  assign rdata_d   = ar_fire ? rd_word : RDATA_O;
  assign rresp_d   = ar_fire ? ((rd_hit_en | rd_hit_id) ? `UIRQ_RESP_OKAY
                                                       : `UIRQ_RESP_SLVERR) : RRESP_O;

  // ======================================================================
  // enable register
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      en_q <= `UIRQ_ENABLE_RST;
    end else begin
      en_q <= en_d;
    end
  end

  // ======================================================================
  // write channel holding registers
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= aw_fire ? AWADDR_I : awaddr_q;
      wdata_q   <= w_fire ? WDATA_I : wdata_q;
      wstrb_q   <= w_fire ? WSTRB_I : wstrb_q;
    end
  end

  // ======================================================================
  // bus outputs
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      AWREADY_O <= 1'b0;
      WREADY_O  <= 1'b0;
      BVALID_O  <= 1'b0;
      BRESP_O   <= `UIRQ_RESP_OKAY;
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= `UIRQ_IDENT_RST;
      RRESP_O   <= `UIRQ_RESP_OKAY;
    end else begin
      AWREADY_O <= awready_d;
      WREADY_O  <= wready_d;
      BVALID_O  <= bvalid_d;
      BRESP_O   <= bresp_d;
      ARREADY_O <= arready_d;
      RVALID_O  <= rvalid_d;
      RDATA_O   <= rdata_d;
      RRESP_O   <= rresp_d;
    end
  end

  // ======================================================================
  // interrupt request output
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= pending;
    end
  end

  // ======================================================================
  // checks

  // request follows pending state one cycle later
  a_irq_follows_pending: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    ##1 (IRQ_O == $past(pending)))
    else $error("interrupt output does not follow pending state");

  // enables come out of reset cleared
  a_enable_reset_clear: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    $past(RST_I) |-> (en_q == 10'h000))
    else $error("enable register not cleared by reset");

  // modem line changes other than clear-to-send set the modem flag
  a_modem_line_sets: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (MODEM_PRESENT && en_modem && (|SRC_I.modem_delta[3:1])) |=> modem_pend)
    else $error("modem change did not raise the modem interrupt");

  // auto flow mode without bit 7 ignores clear-to-send changes
  a_cts_auto_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (CTL_I.auto_clear_to_send && !en_cts && SRC_I.modem_delta == 4'h1 &&
     !flag_q[0] && !CTL_I.modem_status_read) |=> !flag_q[0])
    else $error("clear-to-send change raised interrupt without bit 7");

  // plain mode raises the modem flag on clear-to-send change with bit 3
  a_cts_plain_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (MODEM_PRESENT && !CTL_I.auto_clear_to_send && en_modem && SRC_I.modem_delta[0])
    |=> flag_q[0])
    else $error("clear-to-send change lost in plain mode");

  // without modem support bits 3 and 7 never hold a one
  a_no_modem_inert: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    !MODEM_PRESENT |-> (!en_modem && !en_cts && !modem_pend))
    else $error("modem enable bits active on a part without modem");

  // auto-baud bits shown only with their enable
  a_autobaud_bits: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (ident_word[`UIRQ_ID_DONE] == (flag_q[1] && en_done)) &&
    (ident_word[`UIRQ_ID_TMO] == (flag_q[2] && en_tmo)))
    else $error("auto-baud identification bits mis-gated");

  // done event with enable shows in bit 8 next cycle
  a_done_reported: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (SRC_I.autobaud_done_evt && en_done && !en_wr) |=> ident_word[`UIRQ_ID_DONE])
    else $error("auto-baud done event not reported");

  // time-out event with enable shows in bit 9 next cycle
  a_tmo_reported: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (SRC_I.autobaud_timeout_evt && en_tmo && !en_wr) |=> ident_word[`UIRQ_ID_TMO])
    else $error("auto-baud time-out event not reported");

  // line status outranks every other cause
  a_line_first: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    line_pend |-> (cause == uart_irq_pkg::CAUSE_LINE_STATUS))
    else $error("line status not the top cause");

  // returned identification holds its snapshot while waiting
  a_read_frozen: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (RVALID_O && !RREADY_I) |=> (RVALID_O && $stable(RDATA_O)))
    else $error("read data changed during access");

  // event during an identification read is kept for the next one
  a_event_kept: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (id_read && SRC_I.autobaud_done_evt) |=> flag_q[1])
    else $error("event during identification read was lost");

  // returned pending flag and code match the state at acceptance
  a_ident_value: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    id_read |=> (RDATA_O[`UIRQ_ID_PEND] == !$past(pending)) &&
                (RDATA_O[3:1] == $past(cause)) && RVALID_O)
    else $error("identification read returned wrong pending or code");

  // event during an identification read keeps the time-out flag too
  a_tmo_kept: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (id_read && SRC_I.autobaud_timeout_evt) |=> flag_q[2])
    else $error("time-out event during identification read was lost");

  // auto flow mode with bits 3 and 7 raises the modem flag on clear-to-send change
  a_cts_auto_pass: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (MODEM_PRESENT && CTL_I.auto_clear_to_send && en_modem && en_cts &&
     SRC_I.modem_delta[0]) |=> flag_q[0])
    else $error("clear-to-send change lost in auto flow mode");

  // a modem status read without a new change clears the modem flag
  a_modem_read_clear: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (CTL_I.modem_status_read && !modem_set) |=> !flag_q[0])
    else $error("modem flag survived a modem status read");

  // first cycle after reset shows nothing pending
  a_ident_reset: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    $past(RST_I) |-> ((RDATA_O == `UIRQ_IDENT_RST) && !IRQ_O))
    else $error("identification not idle after reset");

endmodule

// [verilog/uart_irq_map.svh]
`ifndef UART_IRQ_MAP_SVH
`define UART_IRQ_MAP_SVH

// ======================================================================
// register byte addresses
`define UIRQ_ENABLE_ADDR   32'hE001_0004
`define UIRQ_IDENT_ADDR    32'hE001_0008

// ======================================================================
// enable register fields
`define UIRQ_EN_MODEM      4'h3
`define UIRQ_EN_CTS        4'h7
`define UIRQ_EN_DONE       4'h8
`define UIRQ_EN_TMO        4'h9
`define UIRQ_EN_MASK_FULL  10'h388
`define UIRQ_EN_MASK_BASIC 10'h300

// ======================================================================
// identification register fields
`define UIRQ_ID_PEND       4'h0
`define UIRQ_ID_CODE_LO    4'h1
`define UIRQ_ID_CODE_HI    4'h3
`define UIRQ_ID_FIFO_LO    4'h6
`define UIRQ_ID_FIFO_HI    4'h7
`define UIRQ_ID_DONE       4'h8
`define UIRQ_ID_TMO        4'h9

// ======================================================================
// reset values and bus responses
`define UIRQ_ENABLE_RST    10'h000
`define UIRQ_IDENT_RST     32'h0000_0001
`define UIRQ_RESP_OKAY     2'h0
`define UIRQ_RESP_SLVERR   2'h2

`endif

// [verilog/uart_irq_pkg.sv]
package uart_irq_pkg;

  // ======================================================================
  // cause field codes of the identification register
  typedef enum logic [2:0] {
    CAUSE_LINE_STATUS = 3'h3,
    CAUSE_DATA_AVAIL  = 3'h2,
    CAUSE_CHAR_TMO    = 3'h6,
    CAUSE_TX_EMPTY    = 3'h1,
    CAUSE_MODEM       = 3'h0
  } cause_t;

  // ======================================================================
  // source events from the neighbouring uart units
  typedef struct packed {
    logic       receive_line_status_cause;
    logic       receive_data_available_cause;
    logic       character_timeout_cause;
    logic       transmit_holding_empty_cause;
    logic [3:0] modem_delta;
    logic       autobaud_done_evt;
    logic       autobaud_timeout_evt;
  } irq_src_t;

  // ======================================================================
  // control levels and clear pulses from the neighbouring uart units
  typedef struct packed {
    logic       divisor_latch_select;
    logic       auto_clear_to_send;
    logic       fifo_enable;
    logic       modem_status_read;
    logic [1:0] autobaud_clear;
  } uart_ctl_t;

endpackage

// [verilog/irq_flag_bank.sv]
`timescale 1ns/100ps

module irq_flag_bank #(
  parameter int N = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] flag_o
);

  // ======================================================================
  // sticky flags, a set in the clearing cycle wins
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag_o[g] <= 1'b0;
        end else if (set_i[g]) begin
          flag_o[g] <= 1'b1;
        end else if (clr_i[g]) begin
          flag_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// [bench/uart_interrupt_enable_identify_bench.sv]
`timescale 1ns/100ps
`include "uart_irq_map.svh"

module uart_interrupt_enable_identify_bench;
  // ======================================================================
  // clock, reset, bus and model state
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    awvalid = 1'b0;
  logic                    wvalid = 1'b0;
  logic                    bready = 1'b0;
  logic                    arvalid = 1'b0;
  logic                    rready = 1'b0;
  logic [31:0]             awaddr = 32'h0000_0000;
  logic [31:0]             wdata = 32'h0000_0000;
  logic [31:0]             araddr = 32'h0000_0000;
  logic                    awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]              bresp, rresp;
  logic [31:0]             rdata;
  uart_irq_pkg::irq_src_t  src = '0;
  uart_irq_pkg::uart_ctl_t ctl = '0;
  int                      n_mismatch = 0;
  int                      checked = 0;
  int                      cycles = 0;
  int                      seed = 80;
  logic [31:0]             en_m = 32'h0000_0000;
  logic                    modem_m = 1'b0;
  logic                    done_m = 1'b0;
  logic                    tmo_m = 1'b0;

  uart_irq_ctrl u_dut (
    .CORE_CLK_I(clk), .RST_I(rst),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr), .AWPROT_I(3'h0),
    .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(4'hF),
    .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr), .ARPROT_I(3'h0),
    .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
    .SRC_I(src), .CTL_I(ctl), .IRQ_O(irq)
  );

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ======================================================================
  // comparisons and verdict
  task automatic report(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_data(input string w, input logic [31:0] e, input logic [31:0] g);
    report(w, e, g);
  endtask
  task automatic chk_resp(input string w, input logic [1:0] e, input logic [1:0] g);
    report(w, {30'h0, e}, {30'h0, g});
  endtask
  task automatic chk_irq(input string w, input logic e, input logic g);
    report(w, {31'h0, e}, {31'h0, g});
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ======================================================================
  // bus master: valid held until taken, answer taken at its ready edge
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    while (1) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // lag delays rready after the address is taken, stretching the access
  task automatic axi_read(input logic [31:0] a, input int lag, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clk) begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (lag == 0);
    end
    while (1) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      else if (!arvalid && !rready) begin
        if (lag <= 1) rready <= 1'b1;
        lag--;
      end
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd_chk(input string w, input logic [31:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, 0, d, r);
    chk_data(w, e, d);
    chk_resp(w, er, r);
  endtask
  task automatic wr_chk(input string w, input logic [31:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    chk_resp(w, er, r);
  endtask
  task automatic wr_en(input logic [31:0] v);
    en_m = v;
    wr_chk("enable write", `UIRQ_ENABLE_ADDR, v, `UIRQ_RESP_OKAY);
    rd_chk("enable readback", `UIRQ_ENABLE_ADDR, v, `UIRQ_RESP_OKAY);
  endtask

  // ======================================================================
  // behavioural model of the identification word
  function automatic logic [31:0] exp_ident();
    logic [2:0] code;
    logic       pend;
    pend = src.receive_line_status_cause | src.receive_data_available_cause |
           src.character_timeout_cause | src.transmit_holding_empty_cause |
           (modem_m & en_m[3]) | (done_m & en_m[8]) | (tmo_m & en_m[9]);
    if (src.receive_line_status_cause) code = 3'h3;
    else if (src.receive_data_available_cause) code = 3'h2;
    else if (src.character_timeout_cause) code = 3'h6;
    else if (src.transmit_holding_empty_cause) code = 3'h1;
    else code = 3'h0;
    return {22'h0, tmo_m & en_m[9], done_m & en_m[8], {2{ctl.fifo_enable}}, 2'h0, code, ~pend};
  endfunction
  task automatic check_id(input string w);
    logic [31:0] e;
    e = exp_ident();
    rd_chk(w, `UIRQ_IDENT_ADDR, e, `UIRQ_RESP_OKAY);
    chk_irq({w, " irq"}, ~e[0], irq);
  endtask
  // event pulses and clear pulses, one cycle each
  task automatic pulse_modem(input logic [3:0] d);
    @(posedge clk) src.modem_delta <= d;
    @(posedge clk) src.modem_delta <= 4'h0;
    repeat (2) @(posedge clk);
    if (en_m[3] && ((d & 4'hE) != 4'h0 || (d[0] && (!ctl.auto_clear_to_send || en_m[7]))))
      modem_m = 1'b1;
  endtask
  task automatic pulse_ab(input logic [1:0] w);
    @(posedge clk) {src.autobaud_timeout_evt, src.autobaud_done_evt} <= w;
    @(posedge clk) {src.autobaud_timeout_evt, src.autobaud_done_evt} <= 2'h0;
    repeat (2) @(posedge clk);
    done_m = done_m | w[0];
    tmo_m = tmo_m | w[1];
  endtask
  task automatic clear_flags(input logic [2:0] w);
    @(posedge clk) {ctl.modem_status_read, ctl.autobaud_clear} <= w;
    @(posedge clk) {ctl.modem_status_read, ctl.autobaud_clear} <= 3'h0;
    repeat (2) @(posedge clk);
    if (w[2]) modem_m = 1'b0;
    if (w[0]) done_m = 1'b0;
    if (w[1]) tmo_m = 1'b0;
  endtask

  // ======================================================================
  // main sequence
  initial begin
    logic [31:0] v;
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  lv;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_irq("irq after reset", 1'b0, irq);
    rd_chk("enable reset", `UIRQ_ENABLE_ADDR, 32'h0, `UIRQ_RESP_OKAY);
    rd_chk("ident reset", `UIRQ_IDENT_ADDR, `UIRQ_IDENT_RST, `UIRQ_RESP_OKAY);
    rd_chk("unmapped read", 32'hE001_000C, 32'h0, `UIRQ_RESP_SLVERR);
    wr_chk("unmapped write", 32'hE001_000C, 32'h0, `UIRQ_RESP_SLVERR);
    wr_chk("ident write", `UIRQ_IDENT_ADDR, 32'h0000_0300, `UIRQ_RESP_OKAY);
    check_id("ident unchanged");
    $display("test map done");
    // modem change with bit 3 set, then masked
    wr_en(32'h0000_0008);
    pulse_modem(4'h4);
    check_id("modem change");
    clear_flags(3'h4);
    check_id("modem cleared");
    wr_en(32'h0000_0000);
    pulse_modem(4'h2);
    check_id("modem masked");
    // clear-to-send change in every flow mode and bit 7 setting
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) ctl.auto_clear_to_send <= i[1];
      wr_en(i[0] ? 32'h0000_0088 : 32'h0000_0008);
      pulse_modem(4'h1);
      check_id("cts change");
      clear_flags(3'h4);
    end
    $display("test modem done");
    // auto-baud events under every enable pair
    for (int i = 0; i < 4; i++) begin
      wr_en(i << 8);
      pulse_ab(2'h3);
      check_id("autobaud");
      clear_flags(3'h3);
    end
    $display("test autobaud done");
    // every mix of level causes, with a pending modem flag underneath
    wr_en(32'h0000_0008);
    pulse_modem(4'h8);
    for (int i = 0; i < 16; i++) begin
      lv = i[3:0];
      @(posedge clk) begin
        {src.receive_line_status_cause, src.receive_data_available_cause,
         src.character_timeout_cause, src.transmit_holding_empty_cause} <= lv;
        ctl.fifo_enable <= 1'($random(seed));
      end
      wr_en(($random(seed) & 32'h0000_0380) | 32'h0000_0008);
      check_id("priority");
    end
    @(posedge clk) {src.receive_line_status_cause, src.receive_data_available_cause,
                    src.character_timeout_cause, src.transmit_holding_empty_cause} <= 4'h0;
    clear_flags(3'h7);
    $display("test priority done");
    // events arriving as an identification read is taken, read then stretched
    wr_en(32'h0000_0300);
    v = exp_ident();
    fork
      axi_read(`UIRQ_IDENT_ADDR, 8, d, r);
      pulse_ab(2'h3);
    join
    chk_data("ident frozen", v, d);
    check_id("event kept");
    clear_flags(3'h3);
    $display("test freeze done");
    // enable register hidden while the divisor latch is selected
    @(posedge clk) ctl.divisor_latch_select <= 1'b1;
    wr_chk("latch write", `UIRQ_ENABLE_ADDR, 32'h0000_0008, `UIRQ_RESP_OKAY);
    rd_chk("latch read", `UIRQ_ENABLE_ADDR, 32'h0, `UIRQ_RESP_OKAY);
    @(posedge clk) ctl.divisor_latch_select <= 1'b0;
    rd_chk("enable kept", `UIRQ_ENABLE_ADDR, en_m, `UIRQ_RESP_OKAY);
    $display("test latch done");
    finish_test();
  end
endmodule
